// ==== cause_latch.sv ====
/*
  Qualifies raw event pulses and latches them as pending causes.
  Assumes event inputs are synchronous one-cycle pulses or levels.
*/
`timescale 1ns/100ps
module cause_latch (
    input wire logic clk,
    input wire logic rst,
    irq_cause_if.latch ci
);
    import phy_irq_pkg::*;

    typedef struct packed {
        logic [NUM_CAUSE-1:0] causes;
    } latch_state_t;

    latch_state_t st_ff;
    latch_state_t nxt_st;
    logic [NUM_CAUSE-1:0] qual;

    // ----------------------------------------
    // Cause qualification
    // ----------------------------------------
    function automatic logic [NUM_CAUSE-1:0] qualify(input logic [NUM_CAUSE-1:0] evt, input logic aneg_en,
                                                     input logic adv_all, input logic rxer_ext);
        logic [NUM_CAUSE-1:0] q;
        q = evt;
        q[BIT_SPEED_CHG] = evt[BIT_SPEED_CHG] & aneg_en;
        q[BIT_DUPLEX_CHG] = evt[BIT_DUPLEX_CHG] & aneg_en;
        q[BIT_DOWNSHIFT] = evt[BIT_DOWNSHIFT] & adv_all;
        q[BIT_RX_ERR] = evt[BIT_RX_ERR] & ~rxer_ext;
        q[BIT_RESERVED] = 1'b0;
        return q;
    endfunction

    always_comb begin
        qual = qualify(ci.raw_evt, ci.aneg_en, ci.adv_all, ci.rxer_ext);
        nxt_st = st_ff;
        if (ci.soft_clr || ci.rd_clr) begin
            nxt_st.causes = '0;
        end
        nxt_st.causes = nxt_st.causes | qual;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ci.causes = st_ff.causes;
    assign ci.summary = |(st_ff.causes & ci.mask[NUM_CAUSE-1:0]);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_speed_needs_aneg: assert property (@(posedge clk) disable iff (rst)
        (!ci.aneg_en && !st_ff.causes[BIT_SPEED_CHG]) |=> !st_ff.causes[BIT_SPEED_CHG])
        else $error("speed change latched without negotiation");
    a_downshift_needs_adv: assert property (@(posedge clk) disable iff (rst)
        (!ci.adv_all && !st_ff.causes[BIT_DOWNSHIFT]) |=> !st_ff.causes[BIT_DOWNSHIFT])
        else $error("downshift latched without full advertisement");
    a_rxer_ext_block: assert property (@(posedge clk) disable iff (rst)
        (ci.rxer_ext && !st_ff.causes[BIT_RX_ERR]) |=> !st_ff.causes[BIT_RX_ERR])
        else $error("receive error latched during carrier extension");
    a_event_latches: assert property (@(posedge clk) disable iff (rst)
        ci.raw_evt[1] |=> st_ff.causes[1] && !st_ff.causes[BIT_RESERVED])
        else $error("event not latched");
    a_read_clears: assert property (@(posedge clk) disable iff (rst)
        (ci.rd_clr && qual == '0) |=> st_ff.causes == '0)
        else $error("status read did not clear causes");
endmodule

// ==== irq_cause_if.sv ====
/*
  Carrier between the register front end and the cause latch.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface irq_cause_if;
    import phy_irq_pkg::*;

    logic [NUM_CAUSE-1:0] raw_evt;
    logic aneg_en;
    logic adv_all;
    logic rxer_ext;
    logic rd_clr;
    logic soft_clr;
    logic [DATA_W-1:0] mask;
    logic [NUM_CAUSE-1:0] causes;
    logic summary;

    modport latch (
        input raw_evt, aneg_en, adv_all, rxer_ext, rd_clr, soft_clr, mask,
        output causes, summary
    );

    modport ctrl (
        output raw_evt, aneg_en, adv_all, rxer_ext, rd_clr, soft_clr, mask,
        input causes, summary
    );
endinterface

// ==== mgmt_host.sv ====
/*
  Station management host model: drives the register port as master.
  Assumes read data stands only in the cycle after the read strobe.
*/
`timescale 1ns/100ps
module mgmt_host (
    input wire logic clk,
    output logic [phy_irq_pkg::ADDR_W-1:0] addr,
    output logic [phy_irq_pkg::DATA_W-1:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [phy_irq_pkg::DATA_W-1:0] rdata
);
    import phy_irq_pkg::*;

    initial begin
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
    end

    // --------------------------------
    // Bus cycles, optional idle gap
    // --------------------------------
    task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask

    task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask

    // Write followed by a read with no idle cycle between the strobes
    task automatic write_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                              output logic [DATA_W-1:0] q);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        #1;
        q = rdata;
    endtask

    // Flush stale causes, then set pin enable
    task automatic enable_pin(input logic [DATA_W-1:0] m);
        logic [DATA_W-1:0] junk;
        read(OFS_STAT, junk, 2);
        write(OFS_MASK, m | 16'h8000, 0);
    endtask
endmodule

// ==== phy_irq_aux_top.sv ====
/*
  Interrupt mask, read-to-clear interrupt status and auxiliary
  control/status registers of one transceiver port.
  Assumes all status and event inputs come from logic on CLK, and a
  register port whose read data stands in the cycle after the strobe.
*/
`timescale 1ns/100ps
module phy_irq_aux_top #(
    parameter int unsigned TIMEOUT0_CYCLES = phy_irq_pkg::TMO_CYC_0,
    parameter int unsigned TIMEOUT1_CYCLES = phy_irq_pkg::TMO_CYC_1,
    parameter int unsigned TIMEOUT2_CYCLES = phy_irq_pkg::TMO_CYC_2,
    parameter int unsigned TIMEOUT3_CYCLES = phy_irq_pkg::TMO_CYC_3
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic SOFT_RST,
    // Register port
    input wire logic [phy_irq_pkg::ADDR_W-1:0] ADDR,
    input wire logic [phy_irq_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [phy_irq_pkg::DATA_W-1:0] RDATA,
    // Event sources
    input wire logic [phy_irq_pkg::NUM_CAUSE-1:0] EVT,
    input wire logic RXER_CARRIER_EXT,
    // Port state
    input wire logic ANEG_EN,
    input wire logic ANEG_DONE,
    input wire logic LINK_UP,
    input wire logic [3:0] ADV_ABILITY,
    input wire logic AUTO_MEDIA_SENSE,
    input wire logic MODE_100FX,
    input wire logic XOVER_DONE,
    input wire logic CD_SWAP,
    input wire logic [3:0] PAIR_POL,
    input wire logic DUPLEX_STATE,
    input wire logic [1:0] SPEED_STATE,
    input wire logic [1:0] MEDIA_STATE,
    // Outputs
    output logic MGMT_INTERRUPT_PIN,
    output logic POWER_SAVE_EN,
    output logic [1:0] LINK_TIMEOUT_SEL,
    output logic [phy_irq_pkg::CYC_W-1:0] LINK_TIMEOUT_CYCLES
);
    import phy_irq_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] mask;
        logic [1:0] tmo_sel;
        logic psave;
        logic [CYC_W-1:0] tmo_cyc;
        logic [DATA_W-1:0] rdata;
        logic pin;
    } top_state_t;

    top_state_t st_ff;
    top_state_t nxt_st;

    irq_cause_if ci ();

    logic wr_mask;
    logic wr_aux;
    logic rd_stat;
    logic [DATA_W-1:0] stat_word;
    logic [DATA_W-1:0] aux_word;

    // ----------------------------------------
    // Word builders
    // ----------------------------------------
    function automatic logic [DATA_W-1:0] build_aux(input logic aneg_en, input logic aneg_done,
                                                    input logic link_up, input logic auto_media_sense,
                                                    input logic fx, input logic xover,
                                                    input logic cd_swap, input logic [3:0] pol,
                                                    input logic [1:0] tmo, input logic psave,
                                                    input logic dup, input logic [1:0] spd,
                                                    input logic [1:0] media);
        logic [DATA_W-1:0] w;
        w = '0;
        w[AUX_ANEG_DONE] = aneg_en ? aneg_done : link_up;
        w[AUX_ANEG_OFF] = ~aneg_en | (auto_media_sense & fx);
        w[AUX_XOVER] = xover;
        w[AUX_CD_SWAP] = cd_swap;
        w[AUX_POL_LSB +: 4] = pol;
        w[AUX_TMO_MSB] = tmo[1];
        w[AUX_PSAVE_EN] = psave;
        w[AUX_DUPLEX] = dup;
        w[AUX_SPEED_LSB +: 2] = spd;
        w[AUX_TMO_LSB] = tmo[0];
        w[AUX_MEDIA_LSB +: 2] = media;
        return w;
    endfunction

    function automatic logic [CYC_W-1:0] timeout_cycles(input logic [1:0] sel);
        logic [CYC_W-1:0] c;
        c = '0;
        unique case (sel)
            2'h0: c = CYC_W'(TIMEOUT0_CYCLES);
            2'h1: c = CYC_W'(TIMEOUT1_CYCLES);
            2'h2: c = CYC_W'(TIMEOUT2_CYCLES);
            2'h3: c = CYC_W'(TIMEOUT3_CYCLES);
        endcase
        return c;
    endfunction

    // ----------------------------------------
    // Cause latch
    // ----------------------------------------
    assign ci.raw_evt = EVT;
    assign ci.aneg_en = ANEG_EN;
    assign ci.adv_all = &ADV_ABILITY;
    assign ci.rxer_ext = RXER_CARRIER_EXT;
    assign ci.rd_clr = rd_stat;
    assign ci.soft_clr = SOFT_RST;
    assign ci.mask = st_ff.mask;

    cause_latch u_latch (
        .clk (CLK),
        .rst (SYS_RST),
        .ci  (ci.latch)
    );

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    assign wr_mask = WR && (ADDR == OFS_MASK);
    assign wr_aux = WR && (ADDR == OFS_AUX);
    assign rd_stat = RD && (ADDR == OFS_STAT);

    always_comb begin
        stat_word = {ci.summary, ci.causes};
        aux_word = build_aux(ANEG_EN, ANEG_DONE, LINK_UP, AUTO_MEDIA_SENSE, MODE_100FX, XOVER_DONE,
                             CD_SWAP, PAIR_POL, st_ff.tmo_sel, st_ff.psave, DUPLEX_STATE,
                             SPEED_STATE, MEDIA_STATE);
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // Sticky fields ignore SOFT_RST
        if (wr_mask) begin
            nxt_st.mask = WDATA;
        end
        if (wr_aux) begin
            nxt_st.tmo_sel = {WDATA[AUX_TMO_MSB], WDATA[AUX_TMO_LSB]};
            nxt_st.psave = WDATA[AUX_PSAVE_EN];
        end
        nxt_st.tmo_cyc = timeout_cycles(st_ff.tmo_sel);
        nxt_st.rdata = '0;
        if (RD) begin
            unique case (ADDR)
                OFS_MASK: nxt_st.rdata = st_ff.mask;
                OFS_STAT: nxt_st.rdata = stat_word;
                OFS_AUX: nxt_st.rdata = aux_word;
                default: nxt_st.rdata = '0;
            endcase
        end
        // Pin gated by enable only; latching continues regardless
        nxt_st.pin = st_ff.mask[BIT_PIN_EN] & ci.summary;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            st_ff.mask <= MASK_RST;
            st_ff.tmo_sel <= TMO_SEL_RST;
            st_ff.psave <= PSAVE_RST;
            st_ff.tmo_cyc <= '0;
            st_ff.rdata <= '0;
            st_ff.pin <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign RDATA = st_ff.rdata;
    assign MGMT_INTERRUPT_PIN = st_ff.pin;
    assign POWER_SAVE_EN = st_ff.psave;
    assign LINK_TIMEOUT_SEL = st_ff.tmo_sel;
    assign LINK_TIMEOUT_CYCLES = st_ff.tmo_cyc;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_pin_follows_summary: assert property (@(posedge CLK) disable iff (SYS_RST)
        ##1 MGMT_INTERRUPT_PIN == ($past(st_ff.mask[BIT_PIN_EN]) && $past(ci.summary)))
        else $error("interrupt pin does not follow summary");

    a_pin_disabled_low: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!st_ff.mask[BIT_PIN_EN] && !wr_mask) |=> !MGMT_INTERRUPT_PIN)
        else $error("interrupt pin high while disabled");

    a_latch_while_disabled: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!st_ff.mask[BIT_PIN_EN] && EVT[13]) |=> ci.causes[13])
        else $error("cause not latched while pin disabled");

    a_mask_write_read: assert property (@(posedge CLK) disable iff (SYS_RST)
        (wr_mask ##1 (RD && ADDR == OFS_MASK && !WR)) |=> RDATA == $past(WDATA, 2))
        else $error("mask readback differs from write");

    a_mask_sticky: assert property (@(posedge CLK) disable iff (SYS_RST)
        (SOFT_RST && !WR) |=> $stable(st_ff.mask) && $stable(st_ff.tmo_sel) && $stable(st_ff.psave))
        else $error("sticky field changed on software reset");

    a_status_readback: assert property (@(posedge CLK) disable iff (SYS_RST)
        rd_stat |=> RDATA == {$past(ci.summary), $past(ci.causes)})
        else $error("status read returned wrong word");

    a_summary_pending: assert property (@(posedge CLK) disable iff (SYS_RST)
        (ci.causes[10] && st_ff.mask[10]) |-> (ci.summary && stat_word[BIT_SUMMARY]))
        else $error("enabled cause without summary");

    a_summary_masked: assert property (@(posedge CLK) disable iff (SYS_RST)
        ((ci.causes & st_ff.mask[NUM_CAUSE-1:0]) == '0) |-> !ci.summary)
        else $error("summary set without enabled cause");

    a_aux_negotiation: assert property (@(posedge CLK) disable iff (SYS_RST)
        (RD && ADDR == OFS_AUX) |=>
            RDATA[AUX_ANEG_DONE] == ($past(ANEG_EN) ? $past(ANEG_DONE) : $past(LINK_UP)))
        else $error("aux negotiation done bit wrong");

    a_aux_aneg_off: assert property (@(posedge CLK) disable iff (SYS_RST)
        (RD && ADDR == OFS_AUX && !ANEG_EN) |=> RDATA[AUX_ANEG_OFF])
        else $error("aux negotiation disabled bit wrong");

    a_aux_pairs: assert property (@(posedge CLK) disable iff (SYS_RST)
        (RD && ADDR == OFS_AUX) |=> RDATA[AUX_POL_LSB +: 4] == $past(PAIR_POL)
            && RDATA[AUX_XOVER] == $past(XOVER_DONE) && RDATA[AUX_CD_SWAP] == $past(CD_SWAP))
        else $error("aux crossover or polarity bits wrong");

    a_timeout_field: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_aux |=> LINK_TIMEOUT_SEL == {$past(WDATA[AUX_TMO_MSB]), $past(WDATA[AUX_TMO_LSB])}
            ##1 LINK_TIMEOUT_CYCLES == timeout_cycles(LINK_TIMEOUT_SEL))
        else $error("timeout field not taken");

    a_speed_duplex: assert property (@(posedge CLK) disable iff (SYS_RST)
        (RD && ADDR == OFS_AUX) |=> RDATA[AUX_SPEED_LSB +: 2] == $past(SPEED_STATE)
            && RDATA[AUX_DUPLEX] == $past(DUPLEX_STATE))
        else $error("speed or duplex bits wrong");

    a_media_field: assert property (@(posedge CLK) disable iff (SYS_RST)
        (RD && ADDR == OFS_AUX) |=> RDATA[AUX_MEDIA_LSB +: 2] == $past(MEDIA_STATE))
        else $error("media bits wrong");

    a_rdata_idle: assert property (@(posedge CLK) disable iff (SYS_RST)
        !RD |=> RDATA == '0)
        else $error("read data present without read");

    // ----------------------------------------
    // Checks on held state and read words
    // ----------------------------------------
    a_mask_taken: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_mask |=> st_ff.mask == $past(WDATA))
        else $error("mask write not taken");

    a_mask_held: assert property (@(posedge CLK) disable iff (SYS_RST)
        !wr_mask |=> $stable(st_ff.mask))
        else $error("mask changed without write");

    a_pin_clears: assert property (@(posedge CLK) disable iff (SYS_RST)
        (st_ff.mask[BIT_PIN_EN] && !ci.summary) |=> !MGMT_INTERRUPT_PIN)
        else $error("interrupt pin high without summary");

    a_cause_from_event: assert property (@(posedge CLK) disable iff (SYS_RST)
        1'b1 |=> (ci.causes & ~$past(ci.causes) & ~$past(EVT)) == '0)
        else $error("cause set without event");

    a_cause_held: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!rd_stat && !SOFT_RST) |=> (ci.causes & $past(ci.causes)) == $past(ci.causes))
        else $error("cause dropped without status read");

    a_stat_reserved: assert property (@(posedge CLK) disable iff (SYS_RST)
        (RD && ADDR == OFS_STAT) |=> !RDATA[BIT_RESERVED])
        else $error("reserved status bit read as set");

    a_summary_bit: assert property (@(posedge CLK) disable iff (SYS_RST)
        (RD && ADDR == OFS_STAT) |=>
            RDATA[BIT_SUMMARY] == |(RDATA[NUM_CAUSE-1:0] & $past(st_ff.mask[NUM_CAUSE-1:0])))
        else $error("summary bit disagrees with causes");

    a_aux_fiber_sense: assert property (@(posedge CLK) disable iff (SYS_RST)
        (RD && ADDR == OFS_AUX && AUTO_MEDIA_SENSE && MODE_100FX) |=> RDATA[AUX_ANEG_OFF])
        else $error("aux fiber sense bit wrong");

    a_aux_aneg_on: assert property (@(posedge CLK) disable iff (SYS_RST)
        (RD && ADDR == OFS_AUX && ANEG_EN && !(AUTO_MEDIA_SENSE && MODE_100FX)) |=> !RDATA[AUX_ANEG_OFF])
        else $error("aux negotiation disabled bit set");

    a_psave_taken: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_aux |=> POWER_SAVE_EN == $past(WDATA[AUX_PSAVE_EN]))
        else $error("power save enable not taken");

    a_timeout_held: assert property (@(posedge CLK) disable iff (SYS_RST)
        !wr_aux |=> $stable(LINK_TIMEOUT_SEL) && $stable(POWER_SAVE_EN))
        else $error("timeout controls changed without write");

    a_aux_ctrl_read: assert property (@(posedge CLK) disable iff (SYS_RST)
        (RD && ADDR == OFS_AUX) |=> RDATA[AUX_TMO_MSB] == $past(LINK_TIMEOUT_SEL[1])
            && RDATA[AUX_TMO_LSB] == $past(LINK_TIMEOUT_SEL[0])
            && RDATA[AUX_PSAVE_EN] == $past(POWER_SAVE_EN))
        else $error("aux control bits read wrong");
endmodule

// ==== phy_irq_aux_top_tb.sv ====
/*
  Self-checking bench for the interrupt and auxiliary status block.
  Assumes the host model in mgmt_host.sv and short timeout parameters.
*/
`timescale 1ns/100ps
module phy_irq_aux_top_tb;
    import phy_irq_pkg::*;

    localparam int unsigned T0 = 100;
    localparam int unsigned T1 = 200;
    localparam int unsigned T2 = 300;
    localparam int unsigned T3 = 400;

    logic clk, sys_rst, soft_rst, wr, rd, rxer_ext, aneg_en, aneg_done, link_up;
    logic auto_media_sense, fx, xover, cd_swap, dup, pin, psave;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [NUM_CAUSE-1:0] evt;
    logic [3:0] adv, pol;
    logic [1:0] spd, media, tsel;
    logic [CYC_W-1:0] tcyc;
    int fails = 0;
    int check_count = 0;
    int unsigned tmo_tab [4] = '{T0, T1, T2, T3};

    phy_irq_aux_top #(.TIMEOUT0_CYCLES(T0), .TIMEOUT1_CYCLES(T1), .TIMEOUT2_CYCLES(T2),
        .TIMEOUT3_CYCLES(T3)) phy_irq_aux_top_i (
        .CLK(clk), .SYS_RST(sys_rst), .SOFT_RST(soft_rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .EVT(evt), .RXER_CARRIER_EXT(rxer_ext),
        .ANEG_EN(aneg_en), .ANEG_DONE(aneg_done), .LINK_UP(link_up), .ADV_ABILITY(adv),
        .AUTO_MEDIA_SENSE(auto_media_sense), .MODE_100FX(fx), .XOVER_DONE(xover), .CD_SWAP(cd_swap),
        .PAIR_POL(pol), .DUPLEX_STATE(dup), .SPEED_STATE(spd), .MEDIA_STATE(media),
        .MGMT_INTERRUPT_PIN(pin), .POWER_SAVE_EN(psave), .LINK_TIMEOUT_SEL(tsel),
        .LINK_TIMEOUT_CYCLES(tcyc));

    mgmt_host mgmt_host_i (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // --------------------------------
    // Checking helpers
    // --------------------------------
    task automatic chk(input string name, input logic [CYC_W-1:0] seen, input logic [CYC_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        if (fails == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] d;
        mgmt_host_i.read(a, d, 0);
        chk(name, 28'(d), 28'(exp));
    endtask

    task automatic pulse_evt(input logic [NUM_CAUSE-1:0] v);
        @(posedge clk);
        evt <= v;
        @(posedge clk);
        evt <= '0;
    endtask

    task automatic pulse_soft();
        @(posedge clk);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
    endtask

    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic t_reset();
        rd_chk("mask reset", OFS_MASK, 16'h0000);
        rd_chk("status reset", OFS_STAT, 16'h0000);
        rd_chk("unmapped read", 5'h1b, 16'h0000);
        chk("timeout sel reset", 28'(tsel), 28'h1);
        chk("power save reset", 28'(psave), 28'h0);
        chk("timeout cycles reset", tcyc, 28'(T1));
    endtask

    task automatic t_mask();
        logic [DATA_W-1:0] q;
        mgmt_host_i.write_read(OFS_MASK, 16'h5a5a, q);
        chk("mask back to back", 28'(q), 28'h5a5a);
        mgmt_host_i.write(OFS_MASK, 16'hffff, 0);
        mgmt_host_i.write(5'h1b, 16'h0000, 0);
        mgmt_host_i.write(OFS_STAT, 16'hffff, 2);
        rd_chk("mask readback", OFS_MASK, 16'hffff);
        pulse_soft();
        rd_chk("mask after soft reset", OFS_MASK, 16'hffff);
        rd_chk("status ignores writes", OFS_STAT, 16'h0000);
    endtask

    task automatic t_causes();
        mgmt_host_i.write(OFS_MASK, 16'h7fff, 0);
        pulse_evt(15'h7fff);
        rd_chk("all causes", OFS_STAT, 16'hffbf);
        rd_chk("cleared by read", OFS_STAT, 16'h0000);
        @(posedge clk);
        aneg_en <= 1'b0;
        adv <= 4'h7;
        rxer_ext <= 1'b1;
        pulse_evt(15'h7fff);
        rd_chk("gated causes", OFS_STAT, 16'hafba);
        @(posedge clk);
        aneg_en <= 1'b1;
        adv <= 4'hf;
        rxer_ext <= 1'b0;
        mgmt_host_i.write(OFS_MASK, 16'h0001, 0);
        pulse_evt(15'h0002);
        rd_chk("masked cause no summary", OFS_STAT, 16'h0002);
    endtask

    task automatic t_pin();
        mgmt_host_i.enable_pin(16'h2000);
        pulse_evt(15'h2000);
        repeat (2) @(posedge clk);
        #1;
        chk("pin asserted", 28'(pin), 28'h1);
        rd_chk("link cause", OFS_STAT, 16'ha000);
        repeat (2) @(posedge clk);
        #1;
        chk("pin released", 28'(pin), 28'h0);
        mgmt_host_i.write(OFS_MASK, 16'h2000, 0);
        pulse_evt(15'h2000);
        repeat (3) @(posedge clk);
        #1;
        chk("pin inhibited", 28'(pin), 28'h0);
        rd_chk("latching continues", OFS_STAT, 16'ha000);
    endtask

    task automatic t_aux();
        logic [15:0] exp;
        logic [3:0] i;
        for (int k = 0; k < 16; k++) begin
            i = 4'(k);
            @(posedge clk);
            aneg_en <= i[0];
            aneg_done <= i[1];
            link_up <= ~i[1];
            auto_media_sense <= i[2];
            fx <= i[3];
            xover <= i[1];
            cd_swap <= i[2];
            pol <= i;
            dup <= i[0];
            spd <= i[1:0];
            media <= i[3:2];
            mgmt_host_i.write(OFS_AUX, 16'hff3b | {8'h00, i[1], i[2], 3'h0, i[0], 2'h0}, 0);
            exp = {i[0] ? i[1] : ~i[1], ~i[0] | (i[2] & i[3]), i[1], i[2], i, i[1], i[2], i[0], i[1:0], i[0], i[3:2]};
            rd_chk("aux word", OFS_AUX, exp);
            chk("timeout sel", 28'(tsel), 28'(i[1:0]));
            chk("power save", 28'(psave), 28'(i[2]));
            chk("timeout cycles", tcyc, 28'(tmo_tab[i[1:0]]));
        end
        pulse_soft();
        @(posedge clk);
        #1;
        chk("sticky sel", 28'(tsel), 28'h3);
        chk("sticky power save", 28'(psave), 28'h1);
    endtask

    // --------------------------------
    // Main sequence and watchdog
    // --------------------------------
    initial begin
        sys_rst = 1'b1;
        soft_rst = 1'b0;
        evt = '0;
        rxer_ext = 1'b0;
        aneg_en = 1'b1;
        aneg_done = 1'b0;
        link_up = 1'b0;
        adv = 4'hf;
        auto_media_sense = 1'b0;
        fx = 1'b0;
        xover = 1'b0;
        cd_swap = 1'b0;
        pol = 4'h0;
        dup = 1'b0;
        spd = 2'h0;
        media = 2'h0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_mask();
        t_causes();
        t_pin();
        t_aux();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
endmodule

// ==== phy_irq_pkg.sv ====
/*
  Constants for the per-port interrupt and auxiliary status block:
  register offsets, field positions, reset values and timeout counts.
  Assumes a 50 MHz system clock and a 5-bit management register address.
*/
package phy_irq_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int NUM_CAUSE = 15;
    localparam int CYC_W = 28;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_MASK = 5'h19;
    localparam logic [ADDR_W-1:0] OFS_STAT = 5'h1a;
    localparam logic [ADDR_W-1:0] OFS_AUX = 5'h1c;

    // Mask and status field positions
    localparam int BIT_PIN_EN = 15;
    localparam int BIT_SUMMARY = 15;
    localparam int BIT_SPEED_CHG = 14;
    localparam int BIT_DUPLEX_CHG = 12;
    localparam int BIT_RESERVED = 6;
    localparam int BIT_DOWNSHIFT = 2;
    localparam int BIT_RX_ERR = 0;

    // Auxiliary field positions
    localparam int AUX_ANEG_DONE = 15;
    localparam int AUX_ANEG_OFF = 14;
    localparam int AUX_XOVER = 13;
    localparam int AUX_CD_SWAP = 12;
    localparam int AUX_POL_LSB = 8;
    localparam int AUX_TMO_MSB = 7;
    localparam int AUX_PSAVE_EN = 6;
    localparam int AUX_DUPLEX = 5;
    localparam int AUX_SPEED_LSB = 3;
    localparam int AUX_TMO_LSB = 2;
    localparam int AUX_MEDIA_LSB = 0;

    // Reset values
    localparam logic [DATA_W-1:0] MASK_RST = 16'h0000;
    localparam logic [1:0] TMO_SEL_RST = 2'h1;
    localparam logic PSAVE_RST = 1'b0;

    // Link status timeouts
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned TMO_MS_0 = 2300;
    localparam int unsigned TMO_MS_1 = 3300;
    localparam int unsigned TMO_MS_2 = 4300;
    localparam int unsigned TMO_MS_3 = 5300;
    localparam int unsigned TMO_CYC_0 = TMO_MS_0 * CYC_PER_MS;
    localparam int unsigned TMO_CYC_1 = TMO_MS_1 * CYC_PER_MS;
    localparam int unsigned TMO_CYC_2 = TMO_MS_2 * CYC_PER_MS;
    localparam int unsigned TMO_CYC_3 = TMO_MS_3 * CYC_PER_MS;

endpackage
